/* dv/wwcd_props.sv */
// Purpose: port checks for the watchdog configuration decoder
// Assumes: classic wishbone slave, one clock
// Notes:   status reads tie mode, run and period fields together
`timescale 1ns/1ps
`default_nettype none
module wwcd_props
  import wwcd_pkg::*;
(
  // clock and reset
  input wire logic        mclk,
  input wire logic        rstn,
  // bus and result
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [23:0] wb_adr_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wdt_timeout
);
  // ****************
  // checks
  // ****************
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic rd_st;
  logic rd_mp;
  logic rd_cw;
  // reads answered at the status, mode and period, and clock and window indices
  assign rd_st = wb_ack_o && !wb_we_i && wb_adr_i[23:2] == IDX_STATUS;
  assign rd_mp = wb_ack_o && !wb_we_i && wb_adr_i[23:2] == IDX_MODE_PERIOD;
  assign rd_cw = wb_ack_o && !wb_we_i && wb_adr_i[23:2] == IDX_CLOCK_WIN;
  a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_has_req: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_pulse_single: assert property (wdt_timeout |=> !wdt_timeout)
    else $error("timeout longer than one cycle");
  a_mp_fill_ones: assert property (rd_mp |-> wb_dat_o[31:7] == 25'h1)
    else $error("mode byte fill wrong");
  a_cw_fill_ones: assert property (rd_cw |-> wb_dat_o[31:6] == 26'h3)
    else $error("clock byte fill wrong");
  a_off_stopped: assert property (rd_st && wb_dat_o[6:5] == MODE_OFF |-> !wb_dat_o[0])
    else $error("watchdog runs in mode off");
  a_on_running: assert property (rd_st && wb_dat_o[6:5] == MODE_ON |-> wb_dat_o[0])
    else $error("watchdog stopped in mode on");
  a_period_legal: assert property (rd_st |-> wb_dat_o[11:7] <= PS_MAX_FIXED)
    else $error("effective period code out of range");
endmodule : wwcd_props
`default_nettype wire

/* dv/wwcd_top_test.sv */
// Purpose: scenario bench for the watchdog configuration decoder
// Assumes: ticks driven one per cycle, config applied through rstn
// Notes:   por_n only at start, rstn pulsed per scenario
`timescale 1ns/1ps
`default_nettype none
module wwcd_top_test
  import wwcd_pkg::*;
;
  // ****************
  // bench signals
  // ****************
  logic        mclk        = 1'b0;
  logic        rstn        = 1'b0;
  logic        por_n       = 1'b0;
  logic [2:0]  cse         = 3'h0;
  logic [23:0] adr         = 24'h0;
  logic [31:0] wdat        = 32'h0;
  logic [2:0]  tick        = 3'h0;
  logic        sleep       = 1'b0;
  logic        ack;
  logic        tmo;
  logic [31:0] rdat;
  logic [31:0] rd;
  int          error_cnt   = 0;
  int          check_count = 0;
  int          cyc_cnt     = 0;
  int          to_cnt      = 0;
  // 25 MHz clock
  always #20 mclk = ~mclk;
  wwcd_top wwcd_top_inst (.mclk(mclk), .rstn(rstn), .por_n(por_n), .wb_cyc_i(cse[2]),
    .wb_stb_i(cse[1]), .wb_we_i(cse[0]), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat), .low_freq_internal_osc(tick[0]),
    .mid_freq_internal_osc(tick[1]), .secondary_osc(tick[2]), .sleep(sleep),
    .wdt_timeout(tmo));
  // timeout pulse count and hang guard
  always @(posedge mclk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (tmo === 1'b1) to_cnt <= to_cnt + 1;
    if (cyc_cnt == 20000) begin
      error_cnt = error_cnt + 1;
      complete_run;
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic bus(input logic w, input logic [21:0] idx, input logic [7:0] d);
    int n = 0;
    // request raised just after an edge, held until ack is sampled high
    cse  <= {2'b11, w};
    adr  <= {idx, 2'b00};
    wdat <= {24'h0, d};
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = rdat;
    check("bus ack", {31'h0, ack}, 32'h1);
    cse <= 3'h0;
    @(posedge mclk);
  endtask : bus
  task automatic setup(input logic [7:0] mp, input logic [7:0] cw, input logic [7:0] ctrl);
    bus(1'b1, IDX_MODE_PERIOD, mp);
    bus(1'b1, IDX_CLOCK_WIN, cw);
    rstn <= 1'b0;
    @(posedge mclk);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
    bus(1'b1, IDX_CONTROL, ctrl);
    bus(1'b0, IDX_STATUS, 8'h0);
    check("mode", {30'h0, rd[6:5]}, {30'h0, mp[6:5]});
  endtask : setup
  task automatic blank;
    bus(1'b0, IDX_MODE_PERIOD, 8'h0);
    check("config 0", rd, 32'hff);
    bus(1'b0, IDX_CLOCK_WIN, 8'h0);
    check("config 1", rd, 32'hff);
    bus(1'b1, IDX_MODE_PERIOD, 8'h00);
    bus(1'b0, IDX_STATUS, 8'h0);
    check("blank status", {25'h0, rd[11:5]}, {25'h0, PS_SOFT_DEF, MODE_ON});
    bus(1'b0, 22'h300020, 8'h0);
    check("unmapped", rd, 32'h0);
  endtask : blank
  task automatic expiry(input logic [7:0] mp, input logic [7:0] cw, input logic [7:0] ctrl,
                        input int src, input logic slp, input int per);
    int n = 0;
    setup(mp, cw, ctrl);
    tick[src] <= 1'b1;
    sleep     <= slp;
    do begin
      @(negedge mclk);
      n++;
    end while (tmo !== 1'b1 && n < 70);
    @(posedge mclk);
    {tick, sleep} <= 4'h0;
    check("expiry", 32'(n), (per == 0) ? 32'h46 : 32'(per + 1));
  endtask : expiry
  task automatic win(input logic [7:0] cw, input int n, input logic key, input logic op,
                     input int ex, input logic [7:0] ssel);
    int t0;
    setup(8'h60, cw, 8'h00);
    bus(1'b1, IDX_SOFT_SEL, ssel);
    tick[0] <= 1'b1;
    repeat (n) @(posedge mclk);
    tick[0] <= 1'b0;
    bus(1'b0, IDX_STATUS, 8'h0);
    check("window open", {31'h0, rd[1]}, {31'h0, op});
    t0 = to_cnt;
    if (key) begin
      bus(1'b1, IDX_CLEAR, KEY_ARM);
      bus(1'b0, IDX_STATUS, 8'h0);
      check("armed", {31'h0, rd[2]}, 32'h1);
    end
    bus(1'b1, IDX_CLEAR, KEY_CLEAR);
    repeat (2) @(posedge mclk);
    check("early clear", 32'(to_cnt - t0), 32'(ex));
  endtask : win
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  // scenario sequence
  initial begin
    repeat (8) @(posedge mclk);
    rstn  <= 1'b1;
    por_n <= 1'b1;
    blank;
    expiry(8'h00, 8'h07, 8'h01, 0, 1'b0, 0);
    expiry(8'h20, 8'h07, 8'h01, 0, 1'b0, 32);
    expiry(8'h20, 8'h07, 8'h00, 0, 1'b0, 0);
    expiry(8'h40, 8'h07, 8'h01, 0, 1'b1, 0);
    expiry(8'h40, 8'h07, 8'h00, 0, 1'b0, 32);
    expiry(8'h60, 8'h07, 8'h00, 0, 1'b1, 32);
    expiry(8'h00, 8'h3f, 8'h01, 0, 1'b0, 0);
    expiry(8'h60, 8'h0f, 8'h00, 1, 1'b0, 32);
    expiry(8'h60, 8'h0f, 8'h00, 0, 1'b0, 0);
    expiry(8'h60, 8'h17, 8'h00, 2, 1'b0, 32);
    expiry(8'h60, 8'h1f, 8'h00, 0, 1'b0, 32);
    expiry(8'h60, 8'h37, 8'h00, 0, 1'b0, 32);
    expiry(8'h60, 8'h3f, 8'h00, 0, 1'b0, 32);
    expiry(8'h61, 8'h07, 8'h00, 0, 1'b0, 64);
    expiry(8'h73, 8'h07, 8'h00, 0, 1'b0, 32);
    expiry(8'h7f, 8'h07, 8'h00, 0, 1'b0, 32);
    win(8'h00, 27, 1'b1, 1'b0, 1, 8'h38);
    win(8'h00, 28, 1'b1, 1'b1, 0, 8'h38);
    win(8'h05, 8, 1'b1, 1'b1, 0, 8'h38);
    win(8'h06, 1, 1'b1, 1'b1, 0, 8'h38);
    win(8'h00, 27, 1'b0, 1'b0, 0, 8'h38);
    win(8'h07, 5, 1'b0, 1'b1, 0, 8'h38);
    win(8'h07, 5, 1'b0, 1'b0, 1, 8'h00);
    complete_run;
  end
endmodule : wwcd_top_test
bind wwcd_top wwcd_props wwcd_props_inst (.mclk(mclk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o),
  .wb_dat_o(wb_dat_o), .wdt_timeout(wdt_timeout));
`default_nettype wire

/* logic/wwcd_pkg.sv */
// Purpose: constants for the windowed watchdog configuration decoder
// Assumes: 32-bit classic wishbone, word index times four is the byte address
// Notes:   indices follow the configuration byte numbering
`default_nettype none
package wwcd_pkg;
  // ****************************************
  // register indices
  // ****************************************
  localparam logic [21:0] IDX_MODE_PERIOD = 22'h300004; // watchdog_mode_period_config
  localparam logic [21:0] IDX_CLOCK_WIN   = 22'h300005; // watchdog_clock_window_config
  localparam logic [21:0] IDX_CONTROL     = 22'h300010; // watchdog_control_zero
  localparam logic [21:0] IDX_SOFT_SEL    = 22'h300011; // soft clock and window choice
  localparam logic [21:0] IDX_CLEAR       = 22'h300012; // keyed clear
  localparam logic [21:0] IDX_STATUS      = 22'h300013; // live state, read only
  // ****************************************
  // field positions and fill
  // ****************************************
  localparam int MODE_LSB = 5;
  localparam int CLK_LSB  = 3;
  localparam int PS_LSB   = 1;
  localparam logic [7:0] FILL_MODE_PERIOD = 8'h80; // unimplemented bit 7
  localparam logic [7:0] FILL_CLOCK_WIN   = 8'hc0; // unimplemented bits 7:6
  localparam logic [7:0] BLANK_BYTE       = 8'hff;
  // ****************************************
  // codes
  // ****************************************
  localparam logic [1:0] MODE_OFF   = 2'h0;
  localparam logic [1:0] MODE_SOFT  = 2'h1;
  localparam logic [1:0] MODE_AWAKE = 2'h2;
  localparam logic [1:0] MODE_ON    = 2'h3;
  localparam logic [4:0] PS_MAX_FIXED = 5'h12;
  localparam logic [4:0] PS_SOFT      = 5'h1f;
  localparam logic [4:0] PS_SOFT_DEF  = 5'h0b;
  localparam logic [4:0] PS_FALLBACK  = 5'h00;
  localparam logic [4:0] PS_BASE      = 5'h05;
  localparam logic [2:0] CLK_LFO  = 3'h0;
  localparam logic [2:0] CLK_MFO  = 3'h1;
  localparam logic [2:0] CLK_SECONDARY_OSC = 3'h2;
  localparam logic [2:0] CLK_SOFT = 3'h7;
  localparam logic [2:0] WIN_LAST_FIXED = 3'h5;
  localparam logic [2:0] WIN_SOFT       = 3'h7;
  localparam logic [2:0] WIN_EIGHTHS    = 3'h7;
  localparam logic [7:0] KEY_ARM   = 8'h55;
  localparam logic [7:0] KEY_CLEAR = 8'haa;
  localparam int CNT_W = 24;
endpackage : wwcd_pkg
`default_nettype wire

/* logic/wwcd_top.sv */
// Purpose: decode two watchdog configuration bytes and run the windowed watchdog
// Assumes: reference clock ticks are one-cycle enables synchronous to mclk
// Notes:   configuration bytes live on por_n, decoded copies reload at rstn
// Function
// - mode 00 keeps the watchdog off; soft enable does nothing.
// - mode 01 lets the soft enable bit start or stop the watchdog.
// - mode 10 runs while awake, pauses the count in sleep, ignores soft enable.
// - mode 11 runs always, asleep or awake, ignores soft enable.
// - period codes 0 to 18 divide by two to the power five plus code.
// - period code 31 hands period to software, default code 11; others fixed.
// - mode 00 ignores the clock select field for counting; status still reports the decoded clock.
// - clock 000 low, 001 mid, 010 secondary oscillator.
// - clock codes 011 to 110 fall back to the low oscillator.
// - clock code 111 hands the clock choice to software.
// - unimplemented bits of both configuration bytes read as one.
`timescale 1ns/1ps
`default_nettype none
module wwcd_top
  import wwcd_pkg::*;
(
  // clock and resets
  input  wire  logic        mclk,
  input  wire  logic        rstn,
  input  wire  logic        por_n,
  // wishbone slave
  input  wire  logic        wb_cyc_i,
  input  wire  logic        wb_stb_i,
  input  wire  logic        wb_we_i,
  input  wire  logic [23:0] wb_adr_i,
  input  wire  logic [3:0]  wb_sel_i,
  input  wire  logic [31:0] wb_dat_i,
  output var   logic        wb_ack_o,
  output var   logic [31:0] wb_dat_o,
  // reference ticks and power state
  input  wire  logic        low_freq_internal_osc,
  input  wire  logic        mid_freq_internal_osc,
  input  wire  logic        secondary_osc,
  input  wire  logic        sleep,
  // watchdog result
  output var   logic        wdt_timeout
);
  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic [4:0] fix_ps(input logic [4:0] code);
    fix_ps = (code <= PS_MAX_FIXED) ? code : PS_FALLBACK;
  endfunction : fix_ps

  function automatic logic [2:0] fix_clk(input logic [2:0] code);
    fix_clk = (code == CLK_MFO || code == CLK_SECONDARY_OSC) ? code : CLK_LFO;
  endfunction : fix_clk

  // ****************************************
  // state
  // ****************************************
  logic [6:0]       nv_mp_reg,    nv_mp_next;   // mode and period byte
  logic [5:0]       nv_cw_reg,    nv_cw_next;   // clock and window byte
  logic             load_reg,     load_next;
  logic [1:0]       mode_reg,     mode_next;
  logic [4:0]       ps_cfg_reg,   ps_cfg_next;
  logic [2:0]       clk_cfg_reg,  clk_cfg_next;
  logic [2:0]       win_cfg_reg,  win_cfg_next;
  logic             soft_watchdog_enable_reg, soft_en_next;
  logic [4:0]       watchdog_prescale_soft_reg, ps_soft_next;
  logic [2:0]       clk_soft_reg, clk_soft_next;
  logic [2:0]       win_soft_reg, win_soft_next;
  logic             armed_reg,    armed_next;
  logic [CNT_W-1:0] cnt_reg,      cnt_next;
  logic             tmo_reg,      tmo_next;
  logic             ack_reg,      ack_next;
  logic [31:0]      dat_reg,      dat_next;

  // ****************************************
  // live decode
  // ****************************************
  logic             run;
  logic             tick;
  logic [4:0]       ps_eff;
  logic [2:0]       clk_eff;
  logic [2:0]       win_eff;
  logic [CNT_W-1:0] period;
  logic [CNT_W-1:0] closed;
  logic             win_open;
  logic             wr;
  logic             rd;
  logic [21:0]      idx;
  logic             clr_cmd;

  assign idx = wb_adr_i[23:2];
  assign wr  = wb_cyc_i && wb_stb_i && !ack_reg && wb_we_i && wb_sel_i[0];
  assign rd  = wb_cyc_i && wb_stb_i && !ack_reg && !wb_we_i;

  // effective settings from latched copies and soft fields
  always_comb begin
    unique case (mode_reg)
      MODE_OFF:   run = 1'b0;
      MODE_SOFT:  run = soft_watchdog_enable_reg;
      MODE_AWAKE: run = !sleep;
      default:    run = 1'b1;
    endcase
    ps_eff  = (ps_cfg_reg == PS_SOFT) ? fix_ps(watchdog_prescale_soft_reg)
                                      : fix_ps(ps_cfg_reg);
    clk_eff = (clk_cfg_reg == CLK_SOFT) ? fix_clk(clk_soft_reg)
                                        : fix_clk(clk_cfg_reg);
    win_eff = (win_cfg_reg == WIN_SOFT) ? win_soft_reg : win_cfg_reg;
    unique case (clk_eff)
      CLK_MFO:  tick = mid_freq_internal_osc;
      CLK_SECONDARY_OSC: tick = secondary_osc;
      default:  tick = low_freq_internal_osc;
    endcase
    if (mode_reg == MODE_OFF) begin
      tick = 1'b0;
    end
    period = CNT_W'(1) << (PS_BASE + ps_eff);
    if (win_eff <= WIN_LAST_FIXED) begin
      closed = CNT_W'((period >> 3) * CNT_W'(WIN_EIGHTHS - win_eff));
    end else begin
      closed = '0;
    end
    win_open = (cnt_reg >= closed);
  end

  // ****************************************
  // write strobes and keyed clear
  // ****************************************
  logic             wr_mp;
  logic             wr_cw;
  logic             wr_ctrl;
  logic             wr_ssel;
  logic             wr_clr;

  // one strobe per writable index
  assign wr_mp   = wr && (idx == IDX_MODE_PERIOD);
  assign wr_cw   = wr && (idx == IDX_CLOCK_WIN);
  assign wr_ctrl = wr && (idx == IDX_CONTROL);
  assign wr_ssel = wr && (idx == IDX_SOFT_SEL);
  assign wr_clr  = wr && (idx == IDX_CLEAR);
  // clear taken when armed, or when the window is software owned
  assign clr_cmd = wr_clr && (wb_dat_i[7:0] == KEY_CLEAR)
                   && (armed_reg || (win_cfg_reg == WIN_SOFT));

  // ****************************************
  // next state, one process per group
  // ****************************************
  // configuration bytes follow writes only
  always_comb begin
    nv_mp_next = nv_mp_reg;
    nv_cw_next = nv_cw_reg;
    if (wr_mp) begin
      nv_mp_next = wb_dat_i[6:0];
    end
    if (wr_cw) begin
      nv_cw_next = wb_dat_i[5:0];
    end
  end

  // one-shot copy of configuration after reset release
  always_comb begin
    load_next    = 1'b0;
    mode_next    = mode_reg;
    ps_cfg_next  = ps_cfg_reg;
    clk_cfg_next = clk_cfg_reg;
    win_cfg_next = win_cfg_reg;
    if (load_reg) begin
      mode_next    = nv_mp_reg[6:MODE_LSB];
      ps_cfg_next  = nv_mp_reg[4:0];
      clk_cfg_next = nv_cw_reg[5:CLK_LSB];
      win_cfg_next = nv_cw_reg[2:0];
    end
  end

  // software fields and clear key
  always_comb begin
    soft_en_next  = soft_watchdog_enable_reg;
    ps_soft_next  = watchdog_prescale_soft_reg;
    clk_soft_next = clk_soft_reg;
    win_soft_next = win_soft_reg;
    armed_next    = armed_reg;
    if (wr_ctrl) begin
      soft_en_next = wb_dat_i[0];
      ps_soft_next = wb_dat_i[PS_LSB+4:PS_LSB];
    end
    if (wr_ssel) begin
      clk_soft_next = wb_dat_i[2:0];
      win_soft_next = wb_dat_i[5:3];
    end
    // any other value written here drops the key
    if (wr_clr) begin
      armed_next = (wb_dat_i[7:0] == KEY_ARM);
    end
  end

  // bus answer and read data
  always_comb begin
    ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
    dat_next = '0;
    if (rd) begin
      unique case (idx)
        IDX_MODE_PERIOD: dat_next = {24'h0, FILL_MODE_PERIOD | {1'b0, nv_mp_reg}};
        IDX_CLOCK_WIN:   dat_next = {24'h0, FILL_CLOCK_WIN | {2'b0, nv_cw_reg}};
        IDX_CONTROL:     dat_next = {26'h0, watchdog_prescale_soft_reg,
                                     soft_watchdog_enable_reg};
        IDX_SOFT_SEL:    dat_next = {26'h0, win_soft_reg, clk_soft_reg};
        IDX_STATUS:      dat_next = {20'h0, ps_eff, mode_reg, clk_eff[1:0],
                                     armed_reg, win_open, run};
        default:         dat_next = '0;
      endcase
    end
  end

  // counter, early clear and expiry; clear wins over expiry
  always_comb begin
    cnt_next = cnt_reg;
    tmo_next = 1'b0;
    if (clr_cmd) begin
      cnt_next = '0;
      tmo_next = run && !win_open;
    end else if (run && tick) begin
      if (cnt_reg == period - CNT_W'(1)) begin
        cnt_next = '0;
        tmo_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + CNT_W'(1);
      end
    end
    // paused count keeps its value, stopped count restarts from zero
    if (!run) begin
      cnt_next = (mode_reg == MODE_AWAKE) ? cnt_next : '0;
    end
  end

  // ****************************************
  // nonvolatile bytes, set to blank ones only at power-on
  // ****************************************
  always_ff @(posedge mclk or negedge por_n) begin
    if (!por_n) begin
      nv_mp_reg <= BLANK_BYTE[6:0];
      nv_cw_reg <= BLANK_BYTE[5:0];
    end else begin
      nv_mp_reg <= nv_mp_next;
      nv_cw_reg <= nv_cw_next;
    end
  end

  // ****************************************
  // decoded configuration, stopped while in reset
  // ****************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      load_reg    <= 1'b1;
      mode_reg    <= MODE_OFF;
      ps_cfg_reg  <= PS_FALLBACK;
      clk_cfg_reg <= CLK_LFO;
      win_cfg_reg <= WIN_SOFT;
    end else begin
      load_reg    <= load_next;
      mode_reg    <= mode_next;
      ps_cfg_reg  <= ps_cfg_next;
      clk_cfg_reg <= clk_cfg_next;
      win_cfg_reg <= win_cfg_next;
    end
  end

  // ****************************************
  // software fields and key
  // ****************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      soft_watchdog_enable_reg   <= 1'b0;
      watchdog_prescale_soft_reg <= PS_SOFT_DEF;
      clk_soft_reg               <= CLK_LFO;
      win_soft_reg               <= WIN_SOFT;
      armed_reg                  <= 1'b0;
    end else begin
      soft_watchdog_enable_reg   <= soft_en_next;
      watchdog_prescale_soft_reg <= ps_soft_next;
      clk_soft_reg               <= clk_soft_next;
      win_soft_reg               <= win_soft_next;
      armed_reg                  <= armed_next;
    end
  end

  // ****************************************
  // counter and timeout pulse
  // ****************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= '0;
      tmo_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tmo_reg <= tmo_next;
    end
  end

  // ****************************************
  // bus answer
  // ****************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ack_reg <= 1'b0;
      dat_reg <= '0;
    end else begin
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  // outputs straight from flops
  assign wb_ack_o    = ack_reg;
  assign wb_dat_o    = dat_reg;
  assign wdt_timeout = tmo_reg;
endmodule : wwcd_top
`default_nettype wire
